// *** hw/dim_map.vh ***
// Constants for the digital input measurement block
`ifndef DIM_MAP_VH
`define DIM_MAP_VH

`define DIM_CLK_KHZ        100000
`define DIM_CYC_PER_US     100
`define DIM_FREQ_GATE_MS   750
`define DIM_FREQ_MAX_HZ    10000
`define DIM_PERIOD_TMO_S   10
`define DIM_DEBOUNCE_MS    4
`define DIM_FREQ_GATE_CYC  (`DIM_FREQ_GATE_MS * `DIM_CLK_KHZ)
`define DIM_PERIOD_TMO_CYC (`DIM_PERIOD_TMO_S * 1000 * `DIM_CLK_KHZ)
`define DIM_DEBOUNCE_CYC   (`DIM_DEBOUNCE_MS * `DIM_CLK_KHZ)

`define DIM_TYPE_LEVEL     3'h0
`define DIM_TYPE_COUNTER   3'h1
`define DIM_TYPE_FREQ      3'h2
`define DIM_TYPE_PERIOD    3'h3
`define DIM_TYPE_DERIVED   3'h4
`define DIM_TYPE_MANUAL    3'h5
`define DIM_TYPE_TEMP      3'h6

`define DIM_FRAC_BITS      16
`define DIM_SLOPE_ONE      32'h0001_0000
`define DIM_OFFSET_ZERO    32'h0000_0000
`define DIM_ROLL_FREE      32'h0000_0000
`define DIM_EQ_BYTES       128
`define DIM_EQ_ADDR_W      7

`endif

// *** hw/dim_sync.v ***
// Two-stage synchroniser for an external digital input pin
module dim_sync (
  input  wire i_clock,
  input  wire i_reset,
  input  wire i_pin,
  output reg  o_level
);

  reg meta;

  always @(posedge i_clock) begin
    if (i_reset) begin
      meta    <= 1'b0;
      o_level <= 1'b0;
    end else begin
      meta    <= i_pin;
      o_level <= meta;
    end
  end

endmodule

// *** hw/dim_scale.v ***
// Slope multiply and offset add, two cycles from start to done
`include "dim_map.vh"

module dim_scale (
  input  wire        i_clock,
  input  wire        i_reset,
  input  wire        i_start,
  input  wire [31:0] i_value,
  input  wire [31:0] i_slope,
  input  wire [31:0] i_offset,
  output reg         o_done,
  output reg  [31:0] o_result
);

  reg signed [64:0] prod;
  reg        [31:0] off_q;
  reg               stage;

  always @(posedge i_clock) begin
    if (i_reset) begin
      prod     <= 65'h0;
      off_q    <= 32'h0;
      stage    <= 1'b0;
      o_done   <= 1'b0;
      o_result <= 32'h0;
    end else begin
      stage  <= i_start;
      o_done <= stage;
      if (i_start) begin
        // Raw treated as unsigned so full 32-bit counts scale correctly
        prod  <= $signed({1'b0, i_value}) * $signed(i_slope);
        off_q <= i_offset;
      end
      if (stage)
        o_result <= prod[`DIM_FRAC_BITS+31:`DIM_FRAC_BITS] + off_q;
    end
  end

endmodule

// *** hw/dim_top.v ***
// Digital input measurement: level, counter, frequency, period, derived, scaling
// Operation
// - Frequency counts cycles over 750 ms gate
// - Frequency path handles inputs up to 10 kHz
// - Period waits at most 10 s per edge
// - Period ends after one full waveform period
// - Nonzero warmup powers outputs during digital measurement
// - Debounce ignores transitions 4 ms after accepted
// - Zero rollover gives free-running 32-bit count
// - Nonzero rollover wraps to zero above limit
// - Counters keep counting while recording is off
// - Level reading works alongside any other measurement
// - Overlapping frequency or period requests not held
// - Derived result waits for referenced measurement
// - Derived input comes from configured source index
// - Result is raw times slope plus offset
// - Slope resets to 1.0, offset to 0.0
// - Slope and offset apply to equation output
// - Each measurement holds 128-byte equation text
// - Equation flag clear passes raw value unchanged
// - Manual entry value is stored as offset
// - Calibration changes only the offset setting
// - Internal temperature raw reading in Celsius
// - Zero warmup leaves power outputs off
`include "dim_map.vh"

module dim_top #(
  parameter        IW       = 3,
  parameter [31:0] GATE_MS  = `DIM_FREQ_GATE_MS,
  parameter [31:0] GATE_CYC = `DIM_FREQ_GATE_CYC,
  parameter [31:0] TMO_CYC  = `DIM_PERIOD_TMO_CYC,
  parameter [31:0] DEB_CYC  = `DIM_DEBOUNCE_CYC,
  parameter [31:0] CYC_US   = `DIM_CYC_PER_US
) (
  input  wire                i_clock,
  input  wire                i_reset,
  input  wire                i_digital_input_one,
  input  wire                i_digital_input_two,
  input  wire [1:0]          i_debounce_en,
  input  wire [31:0]         i_rollover_one,
  input  wire [31:0]         i_rollover_two,
  input  wire [31:0]         i_temp_celsius,
  input  wire                i_req_valid,
  input  wire [IW-1:0]       i_req_index,
  input  wire [2:0]          i_req_type,
  input  wire                i_req_input,
  input  wire [IW-1:0]       i_req_source,
  input  wire                i_req_warmup,
  input  wire                i_cfg_wr,
  input  wire [IW-1:0]       i_cfg_index,
  input  wire [31:0]         i_cfg_slope,
  input  wire [31:0]         i_cfg_offset,
  input  wire                i_cfg_eq_en,
  input  wire                i_offset_wr,
  input  wire [IW-1:0]       i_offset_index,
  input  wire [31:0]         i_offset_value,
  input  wire                i_eq_wr,
  input  wire [IW-1:0]       i_eq_wr_index,
  input  wire [6:0]          i_eq_wr_addr,
  input  wire [7:0]          i_eq_wr_byte,
  input  wire [IW-1:0]       i_eq_rd_index,
  input  wire [6:0]          i_eq_rd_addr,
  input  wire                i_eq_done,
  input  wire [31:0]         i_eq_result,
  output reg  [7:0]          o_eq_rd_byte,
  output reg                 o_eq_req,
  output reg  [IW-1:0]       o_eq_index,
  output reg  [31:0]         o_eq_value,
  output reg                 o_result_valid,
  output reg  [IW-1:0]       o_result_index,
  output reg  [31:0]         o_result_value,
  output reg                 o_result_timeout,
  output reg  [(1<<IW)-1:0]  o_busy,
  output reg  [1:0]          o_level,
  output reg                 o_switched_power,
  output reg                 o_vref
);

  localparam N = 1 << IW;

  localparam E_IDLE  = 3'h0;
  localparam E_FREQ  = 3'h1;
  localparam E_PRISE = 3'h2;
  localparam E_PFALL = 3'h3;
  localparam E_PEND  = 3'h4;

  localparam P_IDLE  = 2'h0;
  localparam P_EQ    = 2'h1;
  localparam P_SCALE = 2'h2;

  function [31:0] next_count;
    input [31:0] cnt;
    input [31:0] roll;
    begin
      if (roll != `DIM_ROLL_FREE && cnt >= roll)
        next_count = 32'h0;
      else
        next_count = cnt + 32'h1;
    end
  endfunction

  function [31:0] freq_hz;
    input [31:0] cycles;
    reg   [63:0] scaled;
    begin
      scaled  = {32'h0, cycles} * 64'd1000;
      scaled  = scaled / {32'h0, GATE_MS};
      freq_hz = scaled[31:0];
    end
  endfunction

  function [N-1:0] onehot;
    input [IW-1:0] idx;
    begin
      onehot      = {N{1'b0}};
      onehot[idx] = 1'b1;
    end
  endfunction

  function [IW:0] pick;
    input [N-1:0] m;
    integer j;
    begin
      pick = {(IW+1){1'b0}};
      for (j = N - 1; j >= 0; j = j - 1)
        if (m[j])
          pick = {1'b1, j[IW-1:0]};
    end
  endfunction

  wire [1:0]  pins = {i_digital_input_two, i_digital_input_one};
  wire [1:0]  lvl_all;
  wire [1:0]  eng_done;
  wire [1:0]  eng_tmo;
  wire [63:0] eng_raw;
  wire [63:0] cnt_all;

  wire req_f  = i_req_valid && i_req_type == `DIM_TYPE_FREQ;
  wire req_p  = i_req_valid && i_req_type == `DIM_TYPE_PERIOD;
  wire [1:0] start_f = {req_f & i_req_input, req_f & ~i_req_input};
  wire [1:0] start_p = {req_p & i_req_input, req_p & ~i_req_input};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      wire        lvl;
      wire [31:0] roll = (g == 0) ? i_rollover_one : i_rollover_two;
      reg         lvl_d;
      reg         filt;
      reg         filt_d;
      reg         done;
      reg         tmo;
      reg  [2:0]  st;
      reg  [31:0] db_tmr;
      reg  [31:0] count;
      reg  [31:0] gate;
      reg  [31:0] edges;
      reg  [31:0] wt;
      reg  [31:0] tot;
      reg  [31:0] raw;

      dim_sync u_sync (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .i_pin   (pins[g]),
        .o_level (lvl)
      );

      wire rise = lvl & ~lvl_d;
      wire fall = ~lvl & lvl_d;
      wire wt_end = (wt == TMO_CYC - 32'h1);

      always @(posedge i_clock) begin
        if (i_reset) begin
          lvl_d  <= 1'b0;
          filt   <= 1'b0;
          filt_d <= 1'b0;
          done   <= 1'b0;
          tmo    <= 1'b0;
          st     <= E_IDLE;
          db_tmr <= 32'h0;
          count  <= 32'h0;
          gate   <= 32'h0;
          edges  <= 32'h0;
          wt     <= 32'h0;
          tot    <= 32'h0;
          raw    <= 32'h0;
        end else begin
          lvl_d  <= lvl;
          filt_d <= filt;
          done   <= 1'b0;
          if (!i_debounce_en[g]) begin
            filt   <= lvl;
            db_tmr <= 32'h0;
          end else if (db_tmr != 32'h0) begin
            db_tmr <= db_tmr - 32'h1;
          end else if (lvl != filt) begin
            filt   <= lvl;
            db_tmr <= DEB_CYC - 32'h1;
          end
          // Runs regardless of any request or recording state
          if (filt & ~filt_d)
            count <= next_count(count, roll);
          if (start_f[g]) begin
            st    <= E_FREQ;
            gate  <= GATE_CYC - 32'h1;
            edges <= 32'h0;
          end else if (start_p[g]) begin
            st <= E_PRISE;
            wt <= 32'h0;
          end else begin
            case (st)
              E_FREQ: begin
                // Sampled at full clock rate, far above the 10 kHz limit
                if (rise)
                  edges <= edges + 32'h1;
                if (gate == 32'h0) begin
                  st   <= E_IDLE;
                  done <= 1'b1;
                  tmo  <= 1'b0;
                  raw  <= freq_hz(edges + {31'h0, rise});
                end else begin
                  gate <= gate - 32'h1;
                end
              end
              E_PRISE, E_PFALL, E_PEND: begin
                tot <= tot + 32'h1;
                wt  <= wt + 32'h1;
                if (st == E_PRISE && rise) begin
                  st  <= E_PFALL;
                  wt  <= 32'h0;
                  tot <= 32'h1;
                end else if (st == E_PFALL && fall) begin
                  st <= E_PEND;
                  wt <= 32'h0;
                end else if (st == E_PEND && rise) begin
                  st   <= E_IDLE;
                  done <= 1'b1;
                  tmo  <= 1'b0;
                  raw  <= tot / CYC_US;
                end else if (wt_end) begin
                  st   <= E_IDLE;
                  done <= 1'b1;
                  tmo  <= 1'b1;
                  raw  <= 32'h0;
                end
              end
              default: st <= E_IDLE;
            endcase
          end
        end
      end

      assign lvl_all[g]          = lvl;
      assign eng_done[g]         = done;
      assign eng_tmo[g]          = tmo;
      assign eng_raw[g*32+:32]   = raw;
      assign cnt_all[g*32+:32]   = count;
    end
  endgenerate

  reg [N-1:0]  busy;
  reg [N-1:0]  rdy;
  reg [N-1:0]  tmo_m;
  reg [N-1:0]  warm;
  reg [N-1:0]  der;
  reg [N-1:0]  eq_en;
  reg [N-1:0]  own0;
  reg [N-1:0]  own1;
  reg [31:0]   raw_a    [0:N-1];
  reg [31:0]   slope_a  [0:N-1];
  reg [31:0]   offset_a [0:N-1];
  reg [31:0]   result_a [0:N-1];
  reg [IW-1:0] src_a    [0:N-1];
  reg [1:0]    pst;
  reg [IW-1:0] pidx;
  reg          sc_start;
  reg [31:0]   sc_value;
  reg [7:0]    eq_text  [0:N*`DIM_EQ_BYTES-1];

  wire        sc_done;
  wire [31:0] sc_result;
  wire [IW:0] sel = pick(rdy);
  wire        take = (pst == P_IDLE) && sel[IW];

  reg [N-1:0] der_fin;
  reg [N-1:0] next_rdy;
  reg [N-1:0] next_busy;
  reg [N-1:0] imm_set;
  reg [N-1:0] req_oh;
  reg [31:0]  imm_raw;
  integer     k;
  integer     d;

  always @* begin
    req_oh  = i_req_valid ? onehot(i_req_index) : {N{1'b0}};
    imm_set = {N{1'b0}};
    imm_raw = 32'h0;
    case (i_req_type)
      `DIM_TYPE_LEVEL:   begin imm_set = req_oh; imm_raw = {31'h0, lvl_all[i_req_input]}; end
      `DIM_TYPE_COUNTER: begin imm_set = req_oh; imm_raw = cnt_all[i_req_input*32+:32]; end
      `DIM_TYPE_MANUAL:  begin imm_set = req_oh; imm_raw = 32'h0; end
      `DIM_TYPE_TEMP:    begin imm_set = req_oh; imm_raw = i_temp_celsius; end
      default:           imm_set = {N{1'b0}};
    endcase
    for (d = 0; d < N; d = d + 1)
      der_fin[d] = der[d] & busy[d] & ~busy[src_a[d]] & ~rdy[src_a[d]] &
                   ~(pst != P_IDLE && pidx == src_a[d]);
    next_rdy  = (rdy & ~(take ? onehot(sel[IW-1:0]) : {N{1'b0}}))
              | (eng_done[0] ? own0 : {N{1'b0}})
              | (eng_done[1] ? own1 : {N{1'b0}}) | der_fin | imm_set;
    next_busy = busy & ~(eng_done[0] ? own0 : {N{1'b0}})
              & ~(eng_done[1] ? own1 : {N{1'b0}}) & ~der_fin;
    if (req_f || req_p || (i_req_valid && i_req_type == `DIM_TYPE_DERIVED))
      next_busy = next_busy | req_oh;
  end

  always @(posedge i_clock) begin
    if (i_reset) begin
      busy <= {N{1'b0}};
      rdy  <= {N{1'b0}};
      tmo_m <= {N{1'b0}};
      warm <= {N{1'b0}};
      der  <= {N{1'b0}};
      eq_en <= {N{1'b0}};
      own0 <= {N{1'b0}};
      own1 <= {N{1'b0}};
      for (k = 0; k < N; k = k + 1) begin
        raw_a[k]    <= 32'h0;
        slope_a[k]  <= `DIM_SLOPE_ONE;
        offset_a[k] <= `DIM_OFFSET_ZERO;
        result_a[k] <= 32'h0;
        src_a[k]    <= {IW{1'b0}};
      end
      pst <= P_IDLE;
      pidx <= {IW{1'b0}};
      sc_start <= 1'b0;
      sc_value <= 32'h0;
      o_eq_req <= 1'b0;
      o_eq_index <= {IW{1'b0}};
      o_eq_value <= 32'h0;
      o_result_valid <= 1'b0;
      o_result_index <= {IW{1'b0}};
      o_result_value <= 32'h0;
      o_result_timeout <= 1'b0;
      o_busy <= {N{1'b0}};
      o_level <= 2'h0;
      o_switched_power <= 1'b0;
      o_vref <= 1'b0;
    end else begin
      o_result_valid <= 1'b0;
      o_eq_req <= 1'b0;
      sc_start <= 1'b0;
      rdy  <= next_rdy;
      busy <= next_busy;
      own0 <= (eng_done[0] ? own0 & ~own0 : own0) | (start_f[0] | start_p[0] ? req_oh : {N{1'b0}});
      own1 <= (eng_done[1] ? own1 & ~own1 : own1) | (start_f[1] | start_p[1] ? req_oh : {N{1'b0}});
      o_busy  <= busy;
      o_level <= lvl_all;
      // Outputs follow only digital requests that carried a warmup
      o_switched_power <= |(busy & warm);
      o_vref           <= |(busy & warm);
      if (i_req_valid) begin
        warm[i_req_index]  <= (req_f | req_p) & i_req_warmup;
        der[i_req_index]   <= (i_req_type == `DIM_TYPE_DERIVED);
        src_a[i_req_index] <= i_req_source;
      end
      for (k = 0; k < N; k = k + 1) begin
        if (eng_done[0] && own0[k]) begin
          raw_a[k] <= eng_raw[31:0];
          tmo_m[k] <= eng_tmo[0];
        end
        if (eng_done[1] && own1[k]) begin
          raw_a[k] <= eng_raw[63:32];
          tmo_m[k] <= eng_tmo[1];
        end
        if (der_fin[k]) begin
          raw_a[k] <= result_a[src_a[k]];
          tmo_m[k] <= 1'b0;
        end
        if (imm_set[k]) begin
          raw_a[k] <= imm_raw;
          tmo_m[k] <= 1'b0;
        end
      end
      if (i_cfg_wr) begin
        slope_a[i_cfg_index]  <= i_cfg_slope;
        offset_a[i_cfg_index] <= i_cfg_offset;
        eq_en[i_cfg_index]    <= i_cfg_eq_en;
      end
      // Manual entry and calibration share one offset-only write
      if (i_offset_wr)
        offset_a[i_offset_index] <= i_offset_value;
      case (pst)
        P_IDLE: begin
          if (take) begin
            pidx <= sel[IW-1:0];
            if (eq_en[sel[IW-1:0]]) begin
              o_eq_req   <= 1'b1;
              o_eq_index <= sel[IW-1:0];
              o_eq_value <= raw_a[sel[IW-1:0]];
              pst        <= P_EQ;
            end else begin
              sc_value <= raw_a[sel[IW-1:0]];
              sc_start <= 1'b1;
              pst      <= P_SCALE;
            end
          end
        end
        P_EQ: begin
          if (i_eq_done) begin
            sc_value <= i_eq_result;
            sc_start <= 1'b1;
            pst      <= P_SCALE;
          end
        end
        P_SCALE: begin
          if (sc_done) begin
            result_a[pidx]   <= sc_result;
            o_result_valid   <= 1'b1;
            o_result_index   <= pidx;
            o_result_value   <= sc_result;
            o_result_timeout <= tmo_m[pidx];
            pst              <= P_IDLE;
          end
        end
        default: pst <= P_IDLE;
      endcase
    end
  end

  always @(posedge i_clock) begin
    if (i_eq_wr)
      eq_text[{i_eq_wr_index, i_eq_wr_addr}] <= i_eq_wr_byte;
    if (i_reset)
      o_eq_rd_byte <= 8'h0;
    else
      o_eq_rd_byte <= eq_text[{i_eq_rd_index, i_eq_rd_addr}];
  end

  dim_scale u_scale (
    .i_clock  (i_clock),
    .i_reset  (i_reset),
    .i_start  (sc_start),
    .i_value  (sc_value),
    .i_slope  (slope_a[pidx]),
    .i_offset (offset_a[pidx]),
    .o_done   (sc_done),
    .o_result (sc_result)
  );

endmodule

// *** tb/dim_top_sva.sv ***
// Port-level assertions for the digital input measurement top
`include "dim_map.vh"

module dim_chk #(
  parameter [31:0] GATE_CYC = 32'h3e8,
  parameter [31:0] TMO_CYC  = 32'h1f4
) (
  input wire       i_clock,
  input wire       i_reset,
  input wire       i_digital_input_one,
  input wire       i_digital_input_two,
  input wire       i_req_valid,
  input wire [2:0] i_req_type,
  input wire       i_eq_done,
  input wire       o_eq_req,
  input wire       o_result_valid,
  input wire [2:0] o_result_index,
  input wire       o_result_timeout,
  input wire [7:0] o_busy,
  input wire [1:0] o_level,
  input wire       o_switched_power,
  input wire       o_vref
);
  localparam int GMAX = GATE_CYC + 40;
  localparam int PMAX = 3 * TMO_CYC + 40;
  logic [1:0] since;
  logic       eq_wait;
  int         fw, pw;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // Sync flops still hold reset values for three edges
  always @(posedge i_clock) begin
    if (i_reset) begin
      since   <= 2'h0;
      eq_wait <= 1'b0;
      fw      <= 0;
      pw      <= 0;
    end else begin
      fw <= (i_req_valid && i_req_type == `DIM_TYPE_FREQ) ? 1 : (o_result_valid || fw == 0) ? 0 : fw + 1;
      pw <= (i_req_valid && i_req_type == `DIM_TYPE_PERIOD) ? 1 : (o_result_valid || pw == 0) ? 0 : pw + 1;
      if (since != 2'h3) begin
        since <= since + 2'h1;
      end
      if (o_eq_req) begin
        eq_wait <= 1'b1;
      end else if (i_eq_done) begin
        eq_wait <= 1'b0;
      end
    end
  end
  a_reset_quiet: assert property (disable iff (1'b0)
    i_reset |=> !o_result_valid && !o_eq_req && o_busy == 8'h00 && !o_switched_power) else $error("active after reset");
  a_power_pair: assert property (o_switched_power == o_vref) else $error("power and vref differ");
  a_power_busy: assert property (
    o_switched_power |-> |(o_busy | $past(o_busy))) else $error("power on with nothing busy");
  a_result_owner: assert property (
    o_result_valid |-> !(|(o_busy & (8'h01 << o_result_index)))) else $error("result from busy slot");
  a_valid_pulse: assert property (o_result_valid |=> !o_result_valid) else $error("valid not a pulse");
  a_eq_pulse: assert property (o_eq_req |=> !o_eq_req) else $error("equation request not a pulse");
  a_eq_resume: assert property (eq_wait && i_eq_done |-> ##[4:5] o_result_valid) else $error("no result after eq");
  a_level_track: assert property (
    since == 2'h3 |-> o_level == {$past(i_digital_input_two, 3), $past(i_digital_input_one, 3)}) else $error("level lag");
  a_freq_bound: assert property (fw <= GMAX) else $error("frequency overdue");
  a_period_bound: assert property (pw <= PMAX) else $error("period overdue");
  c_freq: cover property (o_result_valid && o_result_index == 3'h6);
  c_tmo: cover property (o_result_valid && o_result_timeout);
  c_eq: cover property (eq_wait && i_eq_done);
endmodule

bind dim_top dim_chk #(.GATE_CYC(GATE_CYC), .TMO_CYC(TMO_CYC)) u_chk (.i_clock(i_clock), .i_reset(i_reset),
  .i_digital_input_one(i_digital_input_one), .i_digital_input_two(i_digital_input_two), .i_req_valid(i_req_valid),
  .i_req_type(i_req_type), .i_eq_done(i_eq_done), .o_eq_req(o_eq_req), .o_result_valid(o_result_valid),
  .o_result_index(o_result_index), .o_result_timeout(o_result_timeout), .o_busy(o_busy), .o_level(o_level),
  .o_switched_power(o_switched_power), .o_vref(o_vref));

// *** tb/dim_sensor.sv ***
// Square wave and pulse sensor model for both digital inputs
module dim_sensor (
  input  wire        i_clock,
  input  wire [15:0] i_half_one,
  input  wire        i_level_one,
  input  wire        i_go,
  input  wire [7:0]  i_count,
  input  wire [15:0] i_half_two,
  input  wire        i_bounce,
  output logic       o_pin_one,
  output logic       o_pin_two,
  output logic       o_idle
);
  timeunit 1ns;
  timeprecision 1ns;
  int t1 = 0;
  int t2 = 0;
  int left = 0;
  initial begin
    o_pin_one = 1'b0;
    o_pin_two = 1'b0;
  end
  assign o_idle = (left == 0);
  // Pins move on the falling edge, clear of the sampling edge
  always @(negedge i_clock) begin
    t1++;
    if (i_half_one == 16'h0) begin
      o_pin_one <= i_level_one;
    end else if (t1 >= i_half_one) begin
      t1 = 0;
      o_pin_one <= ~o_pin_one;
    end
    if (i_go) begin
      left = 2 * i_count;
      t2 = 0;
    end else if (left > 0) begin
      t2++;
      // Chatter just after each edge but the last, shorter than the filter window
      if (i_bounce && left != 2 * i_count && (t2 == 3 || t2 == 5)) begin
        o_pin_two <= ~o_pin_two;
      end else if (t2 >= i_half_two) begin
        t2 = 0;
        left--;
        o_pin_two <= ~o_pin_two;
      end
    end
  end
endmodule

// *** tb/digital_input_measurement_bench.sv ***
// Self-checking bench for the digital input measurement block
`include "dim_map.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end

module digital_input_measurement_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clock = 1'b0;
  logic        i_reset = 1'b1;
  logic [1:0]  deb = 2'h0;
  logic [31:0] roll = 32'h0, temp = 32'h0, seed = 32'he732dd5b, cnt2 = 32'h0, gv, e;
  logic        rv = 1'b0, rin = 1'b0, rw = 1'b0, cw = 1'b0, ce = 1'b0, ow = 1'b0, ew = 1'b0, edn = 1'b0;
  logic [2:0]  ri = 3'h0, rt = 3'h0, rs = 3'h0, ci = 3'h0, oi = 3'h0, ewi = 3'h0, eri = 3'h0, gi;
  logic [31:0] cs = 32'h0, co = 32'h0, ov = 32'h0, eres = 32'h0;
  logic [6:0]  ewa = 7'h0, era = 7'h0;
  logic [7:0]  ewb = 8'h0, pc = 8'h0, erb, busy;
  logic [15:0] h1 = 16'h0;
  logic        l1 = 1'b1, pg = 1'b0, pb = 1'b0, pin1, pin2, idle, eqr, rvld, rtmo, spw, vref, gt;
  logic [2:0]  eqi, ridx;
  logic [31:0] eqv, rval;
  logic [1:0]  lvl;
  int          checked = 0, n_mismatch = 0, gn, cyc = 0;
  always #5 i_clock = ~i_clock;
  dim_sensor u_sen (.i_clock(i_clock), .i_half_one(h1), .i_level_one(l1), .i_go(pg), .i_count(pc),
    .i_half_two(16'h28), .i_bounce(pb), .o_pin_one(pin1), .o_pin_two(pin2), .o_idle(idle));
  // Short gate, timeout and filter keep the run brief
  dim_top #(.GATE_CYC(32'h3e8), .TMO_CYC(32'h1f4), .DEB_CYC(32'h14)) dut (.i_clock(i_clock), .i_reset(i_reset),
    .i_digital_input_one(pin1), .i_digital_input_two(pin2), .i_debounce_en(deb), .i_rollover_one(32'h0),
    .i_rollover_two(roll), .i_temp_celsius(temp), .i_req_valid(rv), .i_req_index(ri), .i_req_type(rt),
    .i_req_input(rin), .i_req_source(rs), .i_req_warmup(rw), .i_cfg_wr(cw), .i_cfg_index(ci), .i_cfg_slope(cs),
    .i_cfg_offset(co), .i_cfg_eq_en(ce), .i_offset_wr(ow), .i_offset_index(oi), .i_offset_value(ov),
    .i_eq_wr(ew), .i_eq_wr_index(ewi), .i_eq_wr_addr(ewa), .i_eq_wr_byte(ewb), .i_eq_rd_index(eri),
    .i_eq_rd_addr(era), .i_eq_done(edn), .i_eq_result(eres), .o_eq_rd_byte(erb), .o_eq_req(eqr), .o_eq_index(eqi),
    .o_eq_value(eqv), .o_result_valid(rvld), .o_result_index(ridx), .o_result_value(rval), .o_result_timeout(rtmo),
    .o_busy(busy), .o_level(lvl), .o_switched_power(spw), .o_vref(vref));
  function automatic [31:0] nx(input [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic [31:0] sc(input [31:0] r, input [31:0] s, input [31:0] o);
    logic [63:0] p;
    p = r * s;
    return p[47:16] + o;
  endfunction
  task automatic end_sim;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim;
    end
  end
  task automatic req(input [2:0] i, input [2:0] t, input [2:0] s, input n, input w);
    @(negedge i_clock);
    {ri, rt, rs, rin, rw, rv} = {i, t, s, n, w, 1'b1};
    @(negedge i_clock);
    rv = 1'b0;
  endtask
  task automatic res;
    gn = 0;
    do begin
      @(posedge i_clock);
      #1;
      gn++;
    end while (rvld !== 1'b1 && gn < 3000);
    if (rvld !== 1'b1) n_mismatch++;
    {gi, gv, gt} = {ridx, rval, rtmo};
  endtask
  task automatic cfg(input [2:0] i, input [31:0] s, input [31:0] o, input q);
    @(negedge i_clock);
    {ci, cs, co, ce, cw} = {i, s, o, q, 1'b1};
    @(negedge i_clock);
    cw = 1'b0;
  endtask
  task automatic offs(input [2:0] i, input [31:0] v);
    @(negedge i_clock);
    {oi, ov, ow} = {i, v, 1'b1};
    @(negedge i_clock);
    ow = 1'b0;
  endtask
  task automatic pulses(input [7:0] n, input b);
    {pc, pb, pg} = {n, b, 1'b1};
    repeat (2) @(negedge i_clock);
    pg = 1'b0;
    repeat (4000) if (idle !== 1'b1) @(negedge i_clock);
    repeat (6) @(negedge i_clock);
    for (int k = 0; k < n; k++) cnt2 = (roll != 32'h0 && cnt2 >= roll) ? 32'h0 : cnt2 + 32'h1;
    req(3'h7, `DIM_TYPE_COUNTER, 3'h0, 1'b1, 1'b0);
    res;
  endtask
  initial begin
    repeat (10) @(posedge i_clock);
    @(negedge i_clock);
    i_reset = 1'b0;
    repeat (2) @(negedge i_clock);
    seed = nx(seed);
    temp = seed;
    req(3'h0, `DIM_TYPE_LEVEL, 3'h0, 1'b0, 1'b0);
    res;
    `CHK(gv, 32'h1)
    req(3'h1, `DIM_TYPE_TEMP, 3'h0, 1'b0, 1'b0);
    res;
    `CHK(gv, temp)
    seed = nx(seed);
    offs(3'h2, seed);
    req(3'h2, `DIM_TYPE_MANUAL, 3'h0, 1'b0, 1'b0);
    res;
    `CHK(gv, seed)
    cfg(3'h3, 32'h0002_0000, 32'h7, 1'b0);
    req(3'h3, `DIM_TYPE_LEVEL, 3'h0, 1'b0, 1'b0);
    res;
    `CHK(gv, sc(32'h1, 32'h0002_0000, 32'h7))
    offs(3'h3, 32'h64);
    req(3'h3, `DIM_TYPE_LEVEL, 3'h0, 1'b0, 1'b0);
    res;
    `CHK(gv, sc(32'h1, 32'h0002_0000, 32'h64))
    $display("test scaling done");
    cfg(3'h4, 32'h0003_0000, 32'h1, 1'b1);
    req(3'h4, `DIM_TYPE_LEVEL, 3'h0, 1'b0, 1'b0);
    gn = 0;
    while (eqr !== 1'b1 && gn < 50) begin
      @(posedge i_clock);
      #1;
      gn++;
    end
    `CHK({eqi, eqv}, {3'h4, 32'h1})
    seed = nx(seed);
    @(negedge i_clock);
    {eres, edn} = {16'h0, seed[15:0], 1'b1};
    @(negedge i_clock);
    edn = 1'b0;
    res;
    `CHK(gv, sc(eres, 32'h0003_0000, 32'h1))
    for (int k = 5; k < 7; k++) begin
      @(negedge i_clock);
      {ewi, ewa, ewb, ew} = {k[2:0], 7'h7f, seed[7:0] ^ k[7:0], 1'b1};
    end
    @(negedge i_clock);
    ew = 1'b0;
    for (int k = 5; k < 7; k++) begin
      {eri, era} = {k[2:0], 7'h7f};
      @(negedge i_clock);
      `CHK(erb, seed[7:0] ^ k[7:0])
    end
    $display("test equation done");
    roll = 32'h3;
    pulses(8'h6, 1'b0);
    `CHK(gv, cnt2)
    deb = 2'h2;
    pulses(8'h3, 1'b1);
    `CHK(gv, cnt2)
    roll = 32'h0;
    pulses(8'h5, 1'b0);
    `CHK(gv, cnt2)
    $display("test counter done");
    h1 = 16'h5;
    req(3'h6, `DIM_TYPE_FREQ, 3'h0, 1'b0, 1'b0);
    repeat (500) @(negedge i_clock);
    `CHK(spw, 1'b0)
    res;
    `CHK(gv > 32'h81 && gv < 32'h89, 1'b1)
    // Deliberate overlap; normal traffic waits for completion
    req(3'h6, `DIM_TYPE_FREQ, 3'h0, 1'b0, 1'b1);
    req(3'h7, `DIM_TYPE_FREQ, 3'h0, 1'b0, 1'b0);
    repeat (300) @(negedge i_clock);
    `CHK({spw, vref}, 2'h3)
    repeat (2) begin
      res;
      `CHK(gv > 32'h81 && gv < 32'h89, 1'b1)
    end
    $display("test frequency done");
    h1 = 16'haf;
    req(3'h5, `DIM_TYPE_PERIOD, 3'h0, 1'b0, 1'b0);
    res;
    `CHK({gt, gv}, {1'b0, 32'h3})
    {h1, l1} = {16'h0, 1'b0};
    req(3'h5, `DIM_TYPE_PERIOD, 3'h0, 1'b0, 1'b0);
    res;
    `CHK({gt, gv, gn >= 500 && gn < 540}, {1'b1, 32'h0, 1'b1})
    $display("test period done");
    l1 = 1'b1;
    offs(3'h3, 32'hc8);
    e = sc(32'h1, 32'h0002_0000, 32'hc8);
    req(3'h3, `DIM_TYPE_LEVEL, 3'h0, 1'b0, 1'b0);
    req(3'h0, `DIM_TYPE_DERIVED, 3'h3, 1'b0, 1'b0);
    res;
    `CHK({gi, gv}, {3'h3, e})
    res;
    `CHK({gi, gv}, {3'h0, e})
    $display("test derived done");
    end_sim;
  end
endmodule
